// ===== hdl/lpms_sequencer.sv
// How it works
// - low reset pin or power-on reset forces reset mode.
// - reset mode returns every control register to its default.
// - after power-on reset releases, move on to standby.
// - run request reads zero after reset.
// - standby when run request is zero; everything powered down.
// - writes accepted in standby; settings act right after startup.
// - run request starts reference, bias, oscillator; wait 10 ms.
// - thermal shutdown holds startup mode until the event clears.
// - boost soft start runs 20 ms low current, LEDs forced off.
// - boost start follows startup or converter-run written one.
// - registers written in any order, any bits per write.
// - 8-bit code selects 8 to 20 V feedback divider.
// - at least one minimum switch pulse every cycle while the active load is on.
// - active load on by default; off allows pulse skipping.
// - switch duty cycle limited digitally.
// - converter-run written zero puts the boost in standby.
// - codes below 8 act as 8, above 20 as 20.
`timescale 1ns/100ps
`default_nettype none

module lpms_sequencer #(
   parameter int unsigned STARTUP_CYC   = lpms_pkg::STARTUP_CYC,
   parameter int unsigned SOFTSTART_CYC = lpms_pkg::SOFTSTART_CYC,
   parameter logic [6:0]  DEV_ADDR      = lpms_pkg::DEV_ADDR_DFLT
) (
   input  wire logic          ref_clk,
   input  wire logic          srst,
   input  wire logic          extResetLowN,
   input  wire logic          porActive,
   input  wire logic          thermalShutdownEvent,
   input  wire logic          sclIn,
   input  wire logic          sdaIn,
   output logic               sdaOut,
   output logic               sdaOe,
   input  wire logic          currentTrip,
   input  wire logic          voutHigh,
   output logic               swGate,
   output lpms_pkg::lpms_mode_e mode,
   output lpms_pkg::lpms_ctrl_s ctrl
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      lpms_pkg::lpms_mode_e mode;
      logic [7:0]           voutCode;
      logic                 runReq;
      logic                 boostEn;
      logic                 autoEn;
      logic                 boostUp;
      lpms_pkg::lpms_i2c_e  phase;
      logic [3:0]           bitCnt;
      logic [7:0]           shift;
      logic [7:0]           tx;
      logic [7:0]           ptr;
      logic                 sdaDrv;
      logic                 sclPrev;
      logic                 sdaPrev;
      logic [7:0]           per;
      logic [7:0]           onCnt;
      logic                 gate;
      lpms_pkg::lpms_ctrl_s out;
   } lpms_state_s;

   lpms_state_s s_q;
   lpms_state_s s_d;
   logic        inReset;
   logic        startGo;
   logic        startDone;
   logic        softGo;
   logic        softDone;
   logic        busStart;
   logic        busStop;
   logic        sclRise;
   logic        sclFall;
   logic [7:0]  rdData;

   assign inReset  = srst | ~extResetLowN | porActive;
   assign busStart = sclIn & s_q.sclPrev & s_q.sdaPrev & ~sdaIn;
   assign busStop  = sclIn & s_q.sclPrev & ~s_q.sdaPrev & sdaIn;
   assign sclRise  = sclIn & ~s_q.sclPrev;
   assign sclFall  = ~sclIn & s_q.sclPrev;

   always_comb begin
      unique case (s_q.ptr)
         lpms_pkg::VOUT_ADDR: rdData = s_q.voutCode;
         lpms_pkg::CTRL_ADDR:
            rdData = {5'h00, s_q.autoEn, s_q.boostEn, s_q.runReq};
         lpms_pkg::STAT_ADDR: rdData = {4'h0, s_q.boostUp, s_q.mode};
         default:             rdData = 8'h00;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_d         = s_q;
      s_d.sclPrev = sclIn;
      s_d.sdaPrev = sdaIn;
      // serial slave: writes land in every mode but reset, standby included
      if (busStart) begin
         s_d.phase  = lpms_pkg::I2C_ADDR;
         s_d.bitCnt = 4'h0;
         s_d.sdaDrv = 1'b0;
      end else if (busStop) begin
         s_d.phase  = lpms_pkg::I2C_IDLE;
         s_d.sdaDrv = 1'b0;
      end else if (s_q.phase != lpms_pkg::I2C_IDLE) begin
         if (sclRise) begin
            if (s_q.bitCnt < lpms_pkg::BYTE_DONE) begin
               s_d.shift  = {s_q.shift[6:0], sdaIn};
               s_d.bitCnt = 4'(s_q.bitCnt + 4'h1);
            end else if (s_q.phase == lpms_pkg::I2C_RD && sdaIn) begin
               s_d.phase = lpms_pkg::I2C_IDLE;
            end
         end else if (sclFall) begin
            s_d.sdaDrv = 1'b0;
            if (s_q.bitCnt == lpms_pkg::BYTE_DONE) begin
               s_d.bitCnt = lpms_pkg::ACK_SLOT;
               unique case (s_q.phase)
                  lpms_pkg::I2C_ADDR: begin
                     if (s_q.shift[7:1] == DEV_ADDR) begin
                        s_d.sdaDrv = 1'b1;
                        s_d.phase  = s_q.shift[0] ? lpms_pkg::I2C_RD
                                                  : lpms_pkg::I2C_REG;
                     end else begin
                        s_d.phase = lpms_pkg::I2C_IDLE;
                     end
                  end
                  lpms_pkg::I2C_REG: begin
                     s_d.ptr    = s_q.shift;
                     s_d.phase  = lpms_pkg::I2C_WR;
                     s_d.sdaDrv = 1'b1;
                  end
                  lpms_pkg::I2C_WR: begin
                     // whole byte lands at once, any register order
                     unique case (s_q.ptr)
                        lpms_pkg::VOUT_ADDR: s_d.voutCode = s_q.shift;
                        lpms_pkg::CTRL_ADDR: begin
                           s_d.runReq  = s_q.shift[lpms_pkg::RUN_BIT];
                           s_d.boostEn = s_q.shift[lpms_pkg::BOOST_BIT];
                           s_d.autoEn  =
                              s_q.shift[lpms_pkg::AUTOLOAD_BIT];
                        end
                        default: ;
                     endcase
                     s_d.ptr    = 8'(s_q.ptr + 8'h01);
                     s_d.sdaDrv = 1'b1;
                  end
                  lpms_pkg::I2C_RD:   s_d.ptr = 8'(s_q.ptr + 8'h01);
                  lpms_pkg::I2C_IDLE: ;
               endcase
            end else if (s_q.bitCnt == lpms_pkg::ACK_SLOT) begin
               s_d.bitCnt = 4'h0;
               if (s_q.phase == lpms_pkg::I2C_RD) begin
                  s_d.tx     = rdData;
                  s_d.sdaDrv = ~rdData[7];
               end
            end else if (s_q.phase == lpms_pkg::I2C_RD) begin
               s_d.tx     = {s_q.tx[6:0], 1'b0};
               s_d.sdaDrv = ~s_q.tx[6];
            end
         end
      end

      // ****************************************************************
      // operating modes
      // ****************************************************************
      unique case (s_q.mode)
         lpms_pkg::MODE_RESET:   s_d.mode = lpms_pkg::MODE_STANDBY;
         lpms_pkg::MODE_STANDBY: begin
            if (s_q.runReq) s_d.mode = lpms_pkg::MODE_STARTUP;
         end
         lpms_pkg::MODE_STARTUP: begin
            if (startDone) begin
               s_d.mode = s_q.boostEn ? lpms_pkg::MODE_BOOST_START
                                      : lpms_pkg::MODE_NORMAL;
            end
         end
         lpms_pkg::MODE_BOOST_START: begin
            if (!s_q.boostEn) begin
               s_d.mode = lpms_pkg::MODE_NORMAL;
            end else if (softDone) begin
               s_d.mode    = lpms_pkg::MODE_NORMAL;
               s_d.boostUp = 1'b1;
            end
         end
         lpms_pkg::MODE_NORMAL: begin
            if (s_q.boostEn && !s_q.boostUp) begin
               s_d.mode = lpms_pkg::MODE_BOOST_START;
            end
         end
      endcase
      if (!s_q.boostEn) s_d.boostUp = 1'b0;
      if (s_q.mode != lpms_pkg::MODE_RESET &&
          s_q.mode != lpms_pkg::MODE_STANDBY) begin
         if (!s_q.runReq) begin
            s_d.mode    = lpms_pkg::MODE_STANDBY;
            s_d.boostUp = 1'b0;
         end else if (thermalShutdownEvent) begin
            s_d.mode    = lpms_pkg::MODE_STARTUP;
            s_d.boostUp = 1'b0;
         end
      end

      // ****************************************************************
      // boost switch: minimum pulse and duty limit
      // ****************************************************************
      if (!s_q.out.boostRun) begin
         s_d.per   = 8'h00;
         s_d.onCnt = 8'h00;
         s_d.gate  = 1'b0;
      end else begin
         s_d.per = (s_q.per == 8'(lpms_pkg::BOOST_PERIOD_CYC - 8'h01))
                 ? 8'h00 : 8'(s_q.per + 8'h01);
         if (s_q.per == 8'(lpms_pkg::BOOST_PERIOD_CYC - 8'h01)) begin
            // skipping only once the active load is off
            s_d.gate  = s_q.out.autoloadEn | ~voutHigh;
            s_d.onCnt = 8'h00;
         end else if (s_q.gate) begin
            s_d.onCnt = 8'(s_q.onCnt + 8'h01);
            if ((s_d.onCnt >= lpms_pkg::MIN_PULSE_CYC &&
                 (currentTrip | voutHigh)) ||
                s_d.onCnt >= lpms_pkg::MAX_ON_CYC) begin
               s_d.gate = 1'b0;
            end
         end
      end

      // defaults while in reset; the serial slave restarts too
      if (inReset) begin
         s_d          = '0;
         s_d.mode     = lpms_pkg::MODE_RESET;
         s_d.voutCode = lpms_pkg::VOUT_RST;
         s_d.runReq   = 1'b0;
         s_d.autoEn   = 1'b1;
         // idle bus level, so release shows no false edge
         s_d.sclPrev  = 1'b1;
         s_d.sdaPrev  = 1'b1;
      end

      // registered controls follow the next mode
      s_d.out.coreEnable  = s_d.mode == lpms_pkg::MODE_STARTUP ||
                            s_d.mode == lpms_pkg::MODE_BOOST_START ||
                            s_d.mode == lpms_pkg::MODE_NORMAL;
      s_d.out.boostRun    = s_d.mode == lpms_pkg::MODE_BOOST_START ||
                            (s_d.mode == lpms_pkg::MODE_NORMAL &&
                             s_d.boostUp);
      s_d.out.softStart   = s_d.mode == lpms_pkg::MODE_BOOST_START;
      s_d.out.ledForceOff = s_d.mode != lpms_pkg::MODE_NORMAL;
      s_d.out.autoloadEn  = s_d.autoEn & s_d.out.boostRun;
      s_d.out.pulseSkipOk = ~s_d.autoEn;
      // gate drops with the run control, not one cycle after it
      if (!s_d.out.boostRun) s_d.gate = 1'b0;
      if (s_d.voutCode < lpms_pkg::VOUT_MIN) begin
         s_d.out.voutSel = lpms_pkg::VOUT_MIN;
      end else if (s_d.voutCode > lpms_pkg::VOUT_MAX) begin
         s_d.out.voutSel = lpms_pkg::VOUT_MAX;
      end else begin
         s_d.out.voutSel = s_d.voutCode;
      end
   end

   // thermal keeps reloading, so the 10 ms restarts once it clears
   assign startGo = s_d.mode == lpms_pkg::MODE_STARTUP &&
                    (s_q.mode != lpms_pkg::MODE_STARTUP ||
                     thermalShutdownEvent);
   assign softGo  = s_d.mode == lpms_pkg::MODE_BOOST_START &&
                    s_q.mode != lpms_pkg::MODE_BOOST_START;

   lpms_delay_timer #(.LEN(STARTUP_CYC)) u_startTmr (
      .ref_clk (ref_clk),
      .srst    (srst),
      .go      (startGo),
      .done    (startDone)
   );

   lpms_delay_timer #(.LEN(SOFTSTART_CYC)) u_softTmr (
      .ref_clk (ref_clk),
      .srst    (srst),
      .go      (softGo),
      .done    (softDone)
   );

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   assign sdaOut = 1'b0;
   assign sdaOe  = s_q.sdaDrv;
   assign swGate = s_q.gate;
   assign mode   = s_q.mode;
   assign ctrl   = s_q.out;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_rstMode;
      (!extResetLowN || porActive) |=> mode == lpms_pkg::MODE_RESET;
   endproperty
   a_rstMode: assert property (p_rstMode)
      else $error("reset input did not force reset mode");

   property p_rstRegs;
      !extResetLowN |=> s_q.voutCode == lpms_pkg::VOUT_RST && s_q.autoEn
                        && !s_q.boostEn;
   endproperty
   a_rstRegs: assert property (p_rstRegs)
      else $error("registers not at defaults in reset");

   property p_porToStby;
      mode == lpms_pkg::MODE_RESET && !inReset
         |=> mode == lpms_pkg::MODE_STANDBY;
   endproperty
   a_porToStby: assert property (p_porToStby)
      else $error("reset release did not reach standby");

   property p_runZero;
      porActive ##1 !inReset |-> !s_q.runReq;
   endproperty
   a_runZero: assert property (p_runZero)
      else $error("run request not zero after reset");

   property p_stbyOff;
      mode == lpms_pkg::MODE_STANDBY |-> !ctrl.coreEnable && !ctrl.boostRun
                                         && !swGate;
   endproperty
   a_stbyOff: assert property (p_stbyOff)
      else $error("circuits active in standby");

   property p_startHold;
      mode == lpms_pkg::MODE_STARTUP && !startDone && s_q.runReq &&
      !inReset |=> mode == lpms_pkg::MODE_STARTUP;
   endproperty
   a_startHold: assert property (p_startHold)
      else $error("startup left before its delay");

   property p_softOut;
      mode == lpms_pkg::MODE_BOOST_START |-> ctrl.softStart &&
                                             ctrl.ledForceOff;
   endproperty
   a_softOut: assert property (p_softOut)
      else $error("soft start outputs wrong");

   property p_clamp;
      ctrl.voutSel >= lpms_pkg::VOUT_MIN && ctrl.voutSel <= lpms_pkg::VOUT_MAX;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("voltage code outside 8..20");

   property p_stopRun;
      mode != lpms_pkg::MODE_RESET && !s_q.runReq && !inReset
         |=> mode == lpms_pkg::MODE_STANDBY;
   endproperty
   a_stopRun: assert property (p_stopRun)
      else $error("run request low did not give standby");

   property p_minPulse;
      $fell(swGate) && ctrl.boostRun && $past(ctrl.boostRun)
         |-> s_q.onCnt >= lpms_pkg::MIN_PULSE_CYC
             && s_q.onCnt <= lpms_pkg::MAX_ON_CYC;
   endproperty
   a_minPulse: assert property (p_minPulse)
      else $error("switch pulse outside min or max width");

   c_normal: cover property (mode == lpms_pkg::MODE_NORMAL);
   c_boost:  cover property (mode == lpms_pkg::MODE_BOOST_START ##1
                             mode == lpms_pkg::MODE_NORMAL);
   c_write:  cover property (s_q.phase == lpms_pkg::I2C_WR && sdaOe);

endmodule : lpms_sequencer

`default_nettype wire

// ===== hdl/lpms_pkg.sv
package lpms_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS    = 4;
   localparam int unsigned STARTUP_DELAY_MS = 10;
   localparam int unsigned SOFTSTART_MS     = 20;
   localparam int unsigned STARTUP_CYC      =
      STARTUP_DELAY_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SOFTSTART_CYC    =
      SOFTSTART_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned TMR_W            = 23;
   localparam int unsigned BOOST_PERIOD_NS  = 1000;
   localparam int unsigned MIN_PULSE_NS     = 45;
   localparam int unsigned MAX_DUTY_PCT     = 90;
   localparam logic [7:0]  BOOST_PERIOD_CYC =
      8'(BOOST_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [7:0]  MIN_PULSE_CYC    =
      8'((MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0]  MAX_ON_CYC       =
      8'(BOOST_PERIOD_NS * MAX_DUTY_PCT / 100 / CLK_PERIOD_NS);

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0]  VOUT_ADDR    = 8'h0D;
   localparam logic [7:0]  CTRL_ADDR    = 8'h0E;
   localparam logic [7:0]  STAT_ADDR    = 8'h0F;
   localparam logic [7:0]  VOUT_MIN     = 8'h08;
   localparam logic [7:0]  VOUT_MAX     = 8'h14;
   localparam logic [7:0]  VOUT_RST     = 8'h08;
   localparam int unsigned RUN_BIT      = 0;
   localparam int unsigned BOOST_BIT    = 1;
   localparam int unsigned AUTOLOAD_BIT = 2;
   // arbitrary value
   localparam logic [6:0]  DEV_ADDR_DFLT = 7'h2A;
   localparam logic [3:0]  BYTE_DONE    = 4'h8;
   localparam logic [3:0]  ACK_SLOT     = 4'h9;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      MODE_RESET, MODE_STANDBY, MODE_STARTUP, MODE_BOOST_START,
      MODE_NORMAL
   } lpms_mode_e;

   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WR, I2C_RD
   } lpms_i2c_e;

   typedef struct packed {
      logic       coreEnable;
      logic       boostRun;
      logic       softStart;
      logic       ledForceOff;
      logic       autoloadEn;
      logic       pulseSkipOk;
      logic [7:0] voutSel;
   } lpms_ctrl_s;

endpackage : lpms_pkg

// ===== hdl/lpms_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module lpms_delay_timer #(
   parameter int unsigned LEN = 16
) (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic go,
   output logic      done
);

   typedef struct packed {
      logic [lpms_pkg::TMR_W-1:0] cnt;
      logic                       busy;
      logic                       done;
   } lpms_tmr_s;

   lpms_tmr_s s_q;
   lpms_tmr_s s_d;

   // go reloads at any time, so holding it freezes the delay
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (go) begin
         s_d.cnt  = lpms_pkg::TMR_W'(LEN - 1);
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         if (s_q.cnt == '0) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;

endmodule : lpms_delay_timer

`default_nettype wire

// ===== sim/lpms_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// host on the two-wire register bus
// ****************************************************************
module lpms_host_model #(
   parameter logic [6:0] DEV = 7'h2A
) (
   input  wire logic ref_clk,
   input  wire logic sdaWire,
   output logic      sclOut,
   output logic      sdaLow
);
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   // phases of 1..4 cycles keep setup and high/low times at 2 clocks or more
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic put_bit(input logic b);
      sdaLow = !b;
      tick(3);
      sclOut = 1'b1;
      tick(4);
      sclOut = 1'b0;
      tick(1);
   endtask : put_bit

   task automatic get_bit(output logic b);
      sdaLow = 1'b0;
      tick(3);
      sclOut = 1'b1;
      tick(2);
      b = sdaWire;
      tick(2);
      sclOut = 1'b0;
      tick(1);
   endtask : get_bit

   task automatic start();
      sdaLow = 1'b0;
      tick(2);
      sclOut = 1'b1;
      tick(3);
      sdaLow = 1'b1;
      tick(3);
      sclOut = 1'b0;
      tick(1);
   endtask : start

   task automatic stop();
      sdaLow = 1'b1;
      tick(2);
      sclOut = 1'b1;
      tick(3);
      sdaLow = 1'b0;
      tick(3);
   endtask : stop

   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = !b;
   endtask : send

   task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                            output logic ok);
      logic a0, a1, a2;
      start();
      send({DEV, 1'b0}, a0);
      send(p, a1);
      send(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                           output logic ok);
      logic a0, a1, a2;
      start();
      send({DEV, 1'b0}, a0);
      send(p, a1);
      start();
      send({DEV, 1'b1}, a2);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      // nack closes the read so the device lets go of the line
      put_bit(1'b1);
      stop();
      ok = a0 & a1 & a2;
   endtask : read_reg
endmodule : lpms_host_model

`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
   localparam int SU = 20;
   localparam int SS = 30;
   logic                 ref_clk, srst, extResetLowN, porActive;
   logic                 thermalShutdownEvent, currentTrip, voutHigh;
   logic                 sclIn, sdaLow, sdaOut, sdaOe, swGate, sdaWire, ok;
   lpms_pkg::lpms_mode_e mode;
   lpms_pkg::lpms_ctrl_s ctrl;
   logic [7:0]           rd;
   int                   miscompares, tests_run, n, h;

   // open drain with pull-up: low while either side pulls
   assign sdaWire = !(sdaOe | sdaLow);

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   lpms_sequencer #(.STARTUP_CYC(SU), .SOFTSTART_CYC(SS),
      .DEV_ADDR(lpms_pkg::DEV_ADDR_DFLT)) i_dut (
      .ref_clk(ref_clk), .srst(srst), .extResetLowN(extResetLowN),
      .porActive(porActive), .thermalShutdownEvent(thermalShutdownEvent),
      .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .currentTrip(currentTrip), .voutHigh(voutHigh), .swGate(swGate),
      .mode(mode), .ctrl(ctrl));

   lpms_host_model #(.DEV(lpms_pkg::DEV_ADDR_DFLT)) i_host (
      .ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclIn), .sdaLow(sdaLow));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s exp %0h got %0h", nm, e, g);
         miscompares++;
      end
   endtask : chk

   task automatic rng(string nm, int lo, int hi, int v);
      tests_run++;
      if (v < lo || v > hi) begin
         $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, v);
         miscompares++;
      end
   endtask : rng

   task automatic wr(logic [7:0] p, logic [7:0] d);
      i_host.write_reg(p, d, ok);
      chk("ack", 1, 16'(ok));
   endtask : wr

   task automatic rr(logic [7:0] p, logic [7:0] e, string nm);
      i_host.read_reg(p, rd, ok);
      chk("ack", 1, 16'(ok));
      chk(nm, 16'(e), 16'(rd));
   endtask : rr

   task automatic waitm(lpms_pkg::lpms_mode_e m, int lo, int hi, string nm);
      n = 0;
      while (mode !== m && n < hi) begin
         step(1);
         n++;
      end
      chk(nm, 16'(m), 16'(mode));
      rng(nm, lo, hi, n);
   endtask : waitm

   // length of the next whole gate pulse; one under way is let pass
   task automatic pulse(output int w);
      n = 0;
      while (swGate === 1'b1 && n < 260) begin
         step(1);
         n++;
      end
      n = 0;
      while (swGate !== 1'b1 && n < 260) begin
         step(1);
         n++;
      end
      chk("gate rise", 1, 16'(swGate));
      w = 0;
      while (swGate === 1'b1 && w < 300) begin
         step(1);
         w++;
      end
   endtask : pulse

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_defaults();
      chk("mode", 16'(lpms_pkg::MODE_STANDBY), 16'(mode));
      chk("sdaOut", 0, 16'(sdaOut));
      chk("core", 0, 16'(ctrl.coreEnable));
      rr(lpms_pkg::VOUT_ADDR, lpms_pkg::VOUT_RST, "vout");
      rr(lpms_pkg::CTRL_ADDR, 8'h04, "ctrl");
      rr(8'h20, 8'h00, "unmapped");
      wr(lpms_pkg::STAT_ADDR, 8'hFF);
      rr(lpms_pkg::STAT_ADDR, 8'h01, "status");
      wr(lpms_pkg::VOUT_ADDR, 8'h0C);
   endtask : t_defaults

   task automatic t_start();
      wr(lpms_pkg::CTRL_ADDR, 8'h07);
      // the write's ACK and STOP use 16 of the startup cycles
      waitm(lpms_pkg::MODE_BOOST_START, SU - 16, SU - 12, "su");
      chk("ledOff", 1, 16'(ctrl.ledForceOff));
      chk("soft", 1, 16'(ctrl.softStart));
      waitm(lpms_pkg::MODE_NORMAL, SS, SS + 4, "ss");
      chk("run", 1, 16'(ctrl.boostRun));
      chk("ledOff", 0, 16'(ctrl.ledForceOff));
      chk("voutSel", 16'h0C, 16'(ctrl.voutSel));
   endtask : t_start

   task automatic t_vout();
      logic [7:0] v [5] = '{8'h00, 8'h07, 8'h11, 8'h15, 8'hFF};
      logic [7:0] x [5] = '{8'h08, 8'h08, 8'h11, 8'h14, 8'h14};
      for (int i = 0; i < 5; i++) begin
         wr(lpms_pkg::VOUT_ADDR, v[i]);
         chk("voutSel", 16'(x[i]), 16'(ctrl.voutSel));
         rr(lpms_pkg::VOUT_ADDR, v[i], "vout rb");
      end
   endtask : t_vout

   task automatic t_switch();
      pulse(h);
      rng("max on", 220, 225, h);
      currentTrip = 1'b1;
      pulse(h);
      rng("min on", 12, 14, h);
      currentTrip = 1'b0;
      voutHigh = 1'b1;
      pulse(h);
      rng("min on vh", 12, 14, h);
      wr(lpms_pkg::CTRL_ADDR, 8'h03);
      chk("autoload", 0, 16'(ctrl.autoloadEn));
      chk("skipOk", 1, 16'(ctrl.pulseSkipOk));
      step(20);
      h = 0;
      repeat (500) begin
         step(1);
         h += int'(swGate === 1'b1);
      end
      chk("skipped", 0, 16'(h));
      voutHigh = 1'b0;
   endtask : t_switch

   task automatic t_boost();
      wr(lpms_pkg::VOUT_ADDR, 8'h08);
      wr(lpms_pkg::CTRL_ADDR, 8'h05);
      chk("run", 0, 16'(ctrl.boostRun));
      chk("mode", 16'(lpms_pkg::MODE_NORMAL), 16'(mode));
      wr(lpms_pkg::CTRL_ADDR, 8'h07);
      waitm(lpms_pkg::MODE_BOOST_START, 0, 2, "reboost");
      waitm(lpms_pkg::MODE_NORMAL, SS - 16, SS - 12, "resoft");
   endtask : t_boost

   task automatic t_thermal();
      thermalShutdownEvent = 1'b1;
      waitm(lpms_pkg::MODE_STARTUP, 0, 2, "tsd");
      step(SU + 10);
      chk("tsd hold", 16'(lpms_pkg::MODE_STARTUP), 16'(mode));
      thermalShutdownEvent = 1'b0;
      waitm(lpms_pkg::MODE_BOOST_START, SU, SU + 4, "tsd end");
      waitm(lpms_pkg::MODE_NORMAL, SS, SS + 4, "ss2");
      wr(lpms_pkg::CTRL_ADDR, 8'h04);
      chk("off", 16'(lpms_pkg::MODE_STANDBY), 16'(mode));
      chk("core", 0, 16'(ctrl.coreEnable));
   endtask : t_thermal

   task automatic t_resets();
      for (int i = 0; i < 2; i++) begin
         wr(lpms_pkg::VOUT_ADDR, 8'h14);
         wr(lpms_pkg::CTRL_ADDR, 8'h01);
         extResetLowN = (i != 0);
         porActive = (i != 0);
         step(3);
         chk("rst", 16'(lpms_pkg::MODE_RESET), 16'(mode));
         chk("rst led", 1, 16'(ctrl.ledForceOff));
         chk("rst vsel", 16'h08, 16'(ctrl.voutSel));
         extResetLowN = 1'b1;
         porActive = 1'b0;
         waitm(lpms_pkg::MODE_STANDBY, 0, 2, "rel");
         rr(lpms_pkg::VOUT_ADDR, 8'h08, "vout");
         rr(lpms_pkg::CTRL_ADDR, 8'h04, "ctrl");
      end
   endtask : t_resets

   // ****************************************************************
   // run
   // ****************************************************************
   task automatic test_done();
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   initial begin
      srst = 1'b1;
      extResetLowN = 1'b1;
      porActive = 1'b0;
      thermalShutdownEvent = 1'b0;
      currentTrip = 1'b0;
      voutHigh = 1'b0;
      miscompares = 0;
      tests_run = 0;
      step(6);
      srst = 1'b0;
      step(2);
      t_defaults();
      t_start();
      t_vout();
      t_switch();
      t_boost();
      t_thermal();
      t_resets();
      test_done();
   end

   // the sequence needs about 10k cycles; this allows four times that
   initial begin
      #160000;
      miscompares++;
      test_done();
   end
endmodule : tb

`default_nettype wire
